// *** dv/tdc_host_mem.sv ***
// Host memory model serving the engine's DMA word accesses
`timescale 1ns/1ns
module tdc_host_mem (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	output logic      [15:0] mem_rdata,
	output logic             mem_ack
);
	// ****************************************
	// Word store, answers alternate prompt and slow
	// ****************************************
	logic [15:0] m [0:255];
	logic [1:0]  wait_q;
	logic        slow_q;
	int          n_wr;
	logic [31:0] wr_addr;
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mem_ack <= 1'b0;
			wait_q  <= 2'h0;
			slow_q  <= 1'b0;
			n_wr    <= 0;
		end else begin
			mem_ack   <= 1'b0;
			// Toggling idle data exposes a sample outside the ack cycle
			mem_rdata <= ~mem_rdata;
			wait_q    <= wait_q + 2'h1;
			if (mem_req && !mem_ack && wait_q >= {slow_q, slow_q}) begin
				mem_ack   <= 1'b1;
				wait_q    <= 2'h0;
				slow_q    <= ~slow_q;
				mem_rdata <= m[mem_addr[8:1]];
				if (mem_we) begin
					m[mem_addr[8:1]] <= mem_wdata;
					n_wr             <= n_wr + 1;
					wr_addr          <= mem_addr;
				end
			end
		end
	end
endmodule

// *** dv/testbench.sv ***
// Self-checking bench of the transmit descriptor-chain engine
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
	$display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module testbench;
	logic ref_clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, mem_req, mem_we;
	logic mem_ack, tx_valid, tx_last, tx_ready, tx_no_crc, tx_done, tx_fail, tx_copy_exp, wsel;
	logic frame_irq, cmd_done;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, tx_data, tx_dest_sap, tx_fs;
	logic [31:0] s_axi_wdata, s_axi_rdata, mem_addr, lfsr, dat;
	logic [15:0] mem_wdata, mem_rdata, tx_station, tx_corr, req;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [2:0]  tx_type, ft;
	logic [8:0]  b;
	logic [47:0] node;
	logic [7:0]  got [$];
	int          failures, n_compared, n_irq, i, k;
	tdc_host_mem hm (.*);
	tdc_engine DUT (.*);
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [15:0] done_w(input logic [15:0] q, input logic [7:0] c, input logic e);
		return {c, q[7:6], e, q[4:2], 2'b10};
	endfunction
	function automatic logic [7:0] byt(input logic [8:0] a);
		return a[0] ? hm.m[a[8:1]][7:0] : hm.m[a[8:1]][15:8];
	endfunction
	function automatic logic [7:0] exp_b(input int p);
		logic [7:0] v;
		v = byt(9'h101 + p[8:0]);
		if (p >= 8 && p <= 13 && !req[7] && ft != tdc_pkg::FT_IFRAME)
			v = node[8 * (13 - p) +: 8];
		if (p == 8 && ft != tdc_pkg::FT_DIRECT && ft != tdc_pkg::FT_IFRAME
			&& hm.m[8'h2F] > tdc_pkg::RT_HDR_MAX)
			v = v | 8'h80;
		return v;
	endfunction
	function automatic logic sig(input int s);
		if (s == 0) return wsel ? s_axi_awready : s_axi_arready;
		if (s == 1) return wsel ? s_axi_bvalid : s_axi_rvalid;
		return cmd_done;
	endfunction
	task automatic finish_test();
		if (failures == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic tmo(input int n);
		if (n >= 3000) begin
			failures++;
			finish_test();
		end
	endtask
	task automatic wt(input int s);
		int n;
		for (n = 0; n < 3000 && sig(s) !== 1'b1; n++) begin
			@(posedge ref_clk);
			#1;
		end
		tmo(n);
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge ref_clk);
		wsel = w;
		s_axi_awaddr  <= a;
		s_axi_araddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid  <= w;
		s_axi_arvalid <= !w;
		s_axi_bready  <= w;
		s_axi_rready  <= !w;
		#1;
		wt(0);
		@(posedge ref_clk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid  <= 1'b0;
		s_axi_arvalid <= 1'b0;
		#1;
		wt(1);
		`CHK(w ? s_axi_bresp : s_axi_rresp, r)
		if (!w) `CHK(s_axi_rdata, d)
		@(posedge ref_clk);
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ****************************************
	// Frame sink with random stalls
	// ****************************************
	always @(posedge ref_clk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			`CHK(tx_last, got.size() == 13)
			got.push_back(tx_data);
		end
		if (frame_irq === 1'b1) n_irq++;
		lfsr     <= nxt(lfsr);
		tx_ready <= lfsr[0] | lfsr[3];
	end
	initial begin
		{rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{tx_ready, tx_done, tx_fail, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{tx_fs, tx_copy_exp, s_axi_wstrb, lfsr, dat} = {8'h00, 1'b1, 4'hF, 32'hB32D1234, 32'hB32D1234};
		node = {dat[15:0], nxt(dat)};
		for (i = 0; i < 256; i++) hm.m[i] = 16'h0000;
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		xfer(1'b0, tdc_pkg::REG_STATUS, 32'h0, tdc_pkg::RESP_OKAY);
		xfer(1'b0, 8'h1C, 32'h0, tdc_pkg::RESP_SLVERR);
		xfer(1'b1, tdc_pkg::REG_LIST, 32'h40, tdc_pkg::RESP_OKAY);
		xfer(1'b1, tdc_pkg::REG_NODE_HI, {16'h0000, node[47:32]}, tdc_pkg::RESP_OKAY);
		xfer(1'b1, tdc_pkg::REG_NODE_LO, node[31:0], tdc_pkg::RESP_OKAY);
		xfer(1'b0, tdc_pkg::REG_NODE_LO, node[31:0], tdc_pkg::RESP_OKAY);
		for (k = 0; k < 3; k++) begin
			ft  = (k == 2) ? tdc_pkg::FT_INVALID : (k == 1) ? 3'h5 : tdc_pkg::FT_DIRECT;
			req = {5'h00, ft[0], ft[1], ft[2], (k == 1) ? 8'hDD : 8'h1C | (k != 0)};
			hm.m[8'h21] = 16'h0001;
			hm.m[8'h22] = req;
			hm.m[8'h23] = 16'h000E;
			hm.m[8'h24] = 16'h0003;
			hm.m[8'h26] = 16'h0101;
			hm.m[8'h27] = 16'h0007;
			hm.m[8'h29] = 16'h0104;
			hm.m[8'h2A] = 16'h0004;
			hm.m[8'h2C] = 16'h010B;
			for (i = 0; i < 14; i++) begin
				dat = nxt(dat);
				b   = 9'h101 + i[8:0];
				hm.m[b[8:1]][(b[0] ? 7 : 15) -: 8] = dat[7:0];
			end
			hm.m[8'h2D] = dat[31:16];
			hm.m[8'h2E] = dat[15:0];
			hm.m[8'h2F] = (k == 1) ? 16'h000F : dat[23:8];
			got.delete();
			xfer(1'b1, tdc_pkg::REG_CTRL, (k == 2) ? 32'h6 : 32'h5, tdc_pkg::RESP_OKAY);
			if (k == 0) begin
				repeat (40) @(posedge ref_clk);
				xfer(1'b0, tdc_pkg::REG_STATUS, 32'h3, tdc_pkg::RESP_OKAY);
				hm.m[8'h22] = req | 16'h0001;
				xfer(1'b1, tdc_pkg::REG_CTRL, 32'h6, tdc_pkg::RESP_OKAY);
			end
			if (k != 2) begin
				for (i = 0; i < 3000 && got.size() < 14; i++) @(posedge ref_clk);
				tmo(i);
				if (k == 1) hm.m[8'h21] = 16'h0040;
				repeat (20) @(posedge ref_clk);
				`CHK(cmd_done, 1'b0)
				tx_fail <= (k == 1);
				tx_done <= 1'b1;
				@(posedge ref_clk);
				tx_done <= 1'b0;
			end
			#1;
			if (k == 1) begin
				repeat (40) @(posedge ref_clk);
				xfer(1'b0, tdc_pkg::REG_STATUS, 32'h3, tdc_pkg::RESP_OKAY);
			end else
				wt(2);
			`CHK(tx_station, hm.m[8'h2D])
			`CHK(tx_dest_sap, hm.m[8'h2E][7:0])
			`CHK(tx_corr, hm.m[8'h2F])
			`CHK(tx_no_crc, req[6])
			`CHK(tx_type, ft)
			`CHK(hm.m[8'h22], done_w(req, (k == 0) ? tdc_pkg::FS_COPIED : (k == 1) ? tdc_pkg::CODE_TXFAIL : tdc_pkg::CODE_BADTYPE, k != 0))
			`CHK(hm.wr_addr, 32'h44)
			`CHK(hm.n_wr, k + 1)
			`CHK(n_irq, k + 1)
			`CHK(got.size(), (k == 2) ? 0 : 14)
			for (i = 0; i < got.size(); i++) `CHK(got[i], exp_b(i))
		end
		finish_test();
	end
endmodule

// *** verilog/tdc_axil_slave.sv ***
// AXI4-Lite register slave of the transmit descriptor-chain engine
`timescale 1ns/1ns
module tdc_axil_slave (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	tdc_reg_if.slv           regs
);
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
	                                      input logic [3:0] be);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				merge[i*8 +: 8] = nw[i*8 +: 8];
		end
	endfunction

	logic        bvalid_q, rvalid_q, link_en_q, start_q, kick_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] list_q, node_lo_q, rdata_q, ctrl_d;
	logic [15:0] node_hi_q;
	wire         wr_fire = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
	wire         rd_fire = s_axi_arvalid & ~rvalid_q;
	wire         wr_hit  = s_axi_awaddr == tdc_pkg::REG_CTRL || s_axi_awaddr == tdc_pkg::REG_LIST
	                     || s_axi_awaddr == tdc_pkg::REG_NODE_HI
	                     || s_axi_awaddr == tdc_pkg::REG_NODE_LO;
	wire         rd_hit  = s_axi_araddr <= tdc_pkg::REG_LAST_WORD && s_axi_araddr[1:0] == 2'b00;
	wire [31:0]  node_hi_w = merge({16'h0000, node_hi_q}, s_axi_wdata, s_axi_wstrb);
	wire [31:0]  ctrl_rd = {29'h0, link_en_q, 2'b00};
	wire [31:0]  stat_rd = {29'h0, regs.list_err, regs.suspended, regs.busy};
	assign ctrl_d = merge(ctrl_rd, s_axi_wdata, s_axi_wstrb);

	assign s_axi_awready = wr_fire;
	assign s_axi_wready  = wr_fire;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = rd_fire;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign regs.start_p   = start_q;
	assign regs.kick_p    = kick_q;
	assign regs.link_en   = link_en_q;
	assign regs.list_addr = list_q;
	assign regs.node_addr = {node_hi_q, node_lo_q};

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bvalid_q  <= 1'b0;
			bresp_q   <= tdc_pkg::RESP_OKAY;
			start_q   <= 1'b0;
			kick_q    <= 1'b0;
			link_en_q <= 1'b0;
			list_q    <= tdc_pkg::RST_WORD;
			node_hi_q <= 16'h0000;
			node_lo_q <= tdc_pkg::RST_WORD;
		end else begin
			start_q <= 1'b0;
			kick_q  <= 1'b0;
			if (s_axi_bvalid & s_axi_bready)
				bvalid_q <= 1'b0;
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_hit ? tdc_pkg::RESP_OKAY : tdc_pkg::RESP_SLVERR;
				unique case (s_axi_awaddr)
					tdc_pkg::REG_CTRL: begin
						start_q   <= ctrl_d[tdc_pkg::CTRL_START];
						kick_q    <= ctrl_d[tdc_pkg::CTRL_KICK];
						link_en_q <= ctrl_d[tdc_pkg::CTRL_LINK_EN];
					end
					tdc_pkg::REG_LIST:    list_q    <= merge(list_q, s_axi_wdata, s_axi_wstrb);
					tdc_pkg::REG_NODE_HI: node_hi_q <= node_hi_w[15:0];
					tdc_pkg::REG_NODE_LO: node_lo_q <= merge(node_lo_q, s_axi_wdata, s_axi_wstrb);
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rvalid_q <= 1'b0;
			rresp_q  <= tdc_pkg::RESP_OKAY;
			rdata_q  <= tdc_pkg::RST_WORD;
		end else begin
			if (s_axi_rvalid & s_axi_rready)
				rvalid_q <= 1'b0;
			if (rd_fire) begin
				rvalid_q <= 1'b1;
				rresp_q  <= rd_hit ? tdc_pkg::RESP_OKAY : tdc_pkg::RESP_SLVERR;
				unique case (s_axi_araddr)
					tdc_pkg::REG_CTRL:      rdata_q <= ctrl_rd;
					tdc_pkg::REG_LIST:      rdata_q <= list_q;
					tdc_pkg::REG_NODE_HI:   rdata_q <= {16'h0000, node_hi_q};
					tdc_pkg::REG_NODE_LO:   rdata_q <= node_lo_q;
					tdc_pkg::REG_STATUS:    rdata_q <= stat_rd;
					tdc_pkg::REG_LAST_LIST: rdata_q <= regs.last_list;
					tdc_pkg::REG_LAST_WORD: rdata_q <= {16'h0000, regs.last_word};
					default:                rdata_q <= tdc_pkg::RST_WORD;
				endcase
			end
		end
	end
endmodule

// *** verilog/tdc_engine.sv ***
// Transmit descriptor-chain DMA engine, top level
// Functional notes
// - Odd 32-bit link marks final list
// - Run until odd link, await last frame
// - Link made even late: keep processing
// - Never write link or length fields
// - Write status only into start list
// - Go bit waited for at anticipated start
// - Per-frame interrupt when start bit4 set
// - Bit6: pass supplied checksum, no generation
// - Bit7 keeps source, else node address; I-frames keep source
// - Bits 8-10 select frame type, 111 invalid
// - Done word: go clear, done set, copies
// - Bit5 error with reason, keep going
// - Report returned status byte, >00 becomes >CC; here only when link_en and tx_copy_exp are set
// - Frame length from start list only
// - Up to three segments, bit0 chains
// - Segment addresses at any byte alignment
// - Header over 14 sets routing bit, not for direct or I-frames
// - Reason codes >23, >28, >F0
// - Start list without go: silent suspend
`timescale 1ns/1ns
module tdc_engine (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             mem_req,
	output logic             mem_we,
	output logic [31:0]      mem_addr,
	output logic [15:0]      mem_wdata,
	input  wire logic [15:0] mem_rdata,
	input  wire logic        mem_ack,
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	output logic             tx_last,
	input  wire logic        tx_ready,
	output logic [2:0]       tx_type,
	output logic             tx_no_crc,
	output logic [15:0]      tx_station,
	output logic [7:0]       tx_dest_sap,
	output logic [15:0]      tx_corr,
	input  wire logic        tx_done,
	input  wire logic        tx_fail,
	input  wire logic [7:0]  tx_fs,
	input  wire logic        tx_copy_exp,
	output logic             frame_irq,
	output logic             cmd_done
);
	typedef enum logic [3:0] {
		S_IDLE  = 4'h0,
		S_CSTAT = 4'h1,
		S_SUSP  = 4'h2,
		S_FWDH  = 4'h3,
		S_FWDL  = 4'h4,
		S_HDR   = 4'h5,
		S_SEGC  = 4'h6,
		S_SEGH  = 4'h7,
		S_SEGL  = 4'h8,
		S_DRD   = 4'h9,
		S_DOUT  = 4'hA,
		S_SEGE  = 4'hB,
		S_LEND  = 4'hC,
		S_TXW   = 4'hD,
		S_WB    = 4'hE,
		S_REFWD = 4'hF
	} tdc_state_e;

	tdc_reg_if regs ();

	tdc_axil_slave u_slave (
		.ref_clk       (ref_clk),
		.rstn          (rstn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.regs          (regs.slv)
	);

	// ****************************************************
	// State and datapath registers
	// ****************************************************
	tdc_state_e  state_q;
	logic        antic_q, end_q, more_q, txv_q, last_q, lerr_q, irq_q, done_q, has_err_q;
	logic [1:0]  seg_q, hidx_q;
	logic [7:0]  err_q, fs_q, byte_q, sap_q;
	logic [15:0] req_q, fsize_q, station_q, hdr_q, cnt_q, sum_q, pos_q, word_q;
	logic [31:0] list_q, sof_q, fwd_q, daddr_q;

	function automatic logic [31:0] seg_ofs(input logic [1:0] seg, input logic [31:0] k);
		seg_ofs = tdc_pkg::OFS_SEG0 + k + tdc_pkg::SEG_STRIDE * {30'h0, seg};
	endfunction

	wire [15:0] cur      = mem_rdata;
	wire        rd_ack   = mem_ack & ~mem_we;
	wire [2:0]  ftype    = {req_q[8], req_q[9], req_q[10]};
	wire        type1    = ftype != tdc_pkg::FT_DIRECT && ftype != tdc_pkg::FT_IFRAME;
	wire [31:0] hdr_ofs  = hidx_q == 2'd0 ? tdc_pkg::OFS_FSIZE :
	                       hidx_q == 2'd1 ? tdc_pkg::OFS_STATION :
	                       hidx_q == 2'd2 ? tdc_pkg::OFS_SAP : tdc_pkg::OFS_HDRLEN;
	wire        in_sa    = pos_q >= tdc_pkg::SA_FIRST_POS && pos_q <= tdc_pkg::SA_LAST_POS;
	wire [5:0]  sa_sh    = 6'(8 * (tdc_pkg::SA_LAST_POS - pos_q));
	wire [47:0] node_sh  = regs.node_addr >> sa_sh;
	wire [7:0]  mem_byte = daddr_q[0] ? cur[7:0] : cur[15:8];
	wire        sub_sa   = in_sa && !req_q[tdc_pkg::B_PASS_SRC] && ftype != tdc_pkg::FT_IFRAME;
	wire [7:0]  sa_byte  = sub_sa ? node_sh[7:0] : mem_byte;
	wire        rt_set   = pos_q == tdc_pkg::SA_FIRST_POS && type1 && hdr_q > tdc_pkg::RT_HDR_MAX;
	wire [7:0]  out_byte = rt_set ? (sa_byte | 8'h80) : sa_byte;
	wire [7:0]  ok_code  = (fs_q == tdc_pkg::FS_ZERO && regs.link_en && tx_copy_exp)
	                       ? tdc_pkg::FS_COPIED : fs_q;
	wire [15:0] wb_word  = {has_err_q ? err_q : ok_code, req_q[7:6], has_err_q,
	                        req_q[4:2], 1'b1, 1'b0};

	// ****************************************************
	// Host memory port and frame stream outputs
	// ****************************************************
	assign mem_req  = state_q inside {S_CSTAT, S_FWDH, S_FWDL, S_HDR, S_SEGC, S_SEGH, S_SEGL,
	                                  S_DRD, S_WB, S_REFWD};
	assign mem_we   = state_q == S_WB;
	assign mem_wdata = wb_word;
	always_comb begin
		unique case (state_q)
			S_CSTAT: mem_addr = list_q + tdc_pkg::OFS_CSTAT;
			S_FWDH:  mem_addr = list_q + tdc_pkg::OFS_FWD_HI;
			S_FWDL:  mem_addr = list_q + tdc_pkg::OFS_FWD_LO;
			S_REFWD: mem_addr = list_q + tdc_pkg::OFS_FWD_LO;
			S_HDR:   mem_addr = list_q + hdr_ofs;
			S_SEGC:  mem_addr = list_q + seg_ofs(seg_q, 32'h0000_0000);
			S_SEGH:  mem_addr = list_q + seg_ofs(seg_q, 32'h0000_0002);
			S_SEGL:  mem_addr = list_q + seg_ofs(seg_q, 32'h0000_0004);
			S_DRD:   mem_addr = {daddr_q[31:1], 1'b0};
			S_WB:    mem_addr = sof_q + tdc_pkg::OFS_CSTAT;
			default: mem_addr = tdc_pkg::RST_WORD;
		endcase
	end
	assign tx_valid    = txv_q;
	assign tx_data     = byte_q;
	assign tx_last     = last_q;
	assign tx_type     = ftype;
	assign tx_no_crc   = req_q[tdc_pkg::B_PASS_CRC];
	assign tx_station  = station_q;
	assign tx_dest_sap = sap_q;
	assign tx_corr     = hdr_q;
	assign frame_irq   = irq_q;
	assign cmd_done    = done_q;
	assign regs.busy      = state_q != S_IDLE;
	assign regs.suspended = state_q == S_SUSP;
	assign regs.list_err  = lerr_q;
	assign regs.last_list = sof_q;
	assign regs.last_word = word_q;

	// ****************************************************
	// List walker
	// ****************************************************
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= S_IDLE;
			{antic_q, end_q, more_q, txv_q, last_q, lerr_q, irq_q, done_q, has_err_q} <= '0;
			{seg_q, hidx_q, err_q, fs_q, byte_q, sap_q} <= '0;
			{req_q, fsize_q, station_q, hdr_q, cnt_q, sum_q, pos_q, word_q} <= '0;
			{list_q, sof_q, fwd_q, daddr_q} <= '0;
		end else begin
			irq_q  <= 1'b0;
			done_q <= 1'b0;
			unique case (state_q)
				S_IDLE: if (regs.start_p) begin
					list_q  <= regs.list_addr;
					antic_q <= 1'b1;
					lerr_q  <= 1'b0;
					state_q <= S_CSTAT;
				end
				S_CSTAT: if (rd_ack) begin
					end_q <= cur[tdc_pkg::B_END];
					if (antic_q && !cur[tdc_pkg::B_GO]) begin
						state_q <= S_SUSP;
					end else if (antic_q != cur[tdc_pkg::B_START]) begin
						lerr_q  <= 1'b1;
						state_q <= S_IDLE;
					end else begin
						if (antic_q) begin
							req_q     <= cur;
							sof_q     <= list_q;
							sum_q     <= 16'h0000;
							pos_q     <= 16'h0000;
							has_err_q <= 1'b0;
						end
						state_q <= S_FWDH;
					end
				end
				S_SUSP: if (regs.kick_p)
					state_q <= S_CSTAT;
				S_FWDH: if (rd_ack) begin
					fwd_q[31:16] <= cur;
					state_q      <= S_FWDL;
				end
				S_FWDL: if (rd_ack) begin
					fwd_q[15:0] <= cur;
					hidx_q      <= 2'd0;
					seg_q       <= 2'd0;
					state_q     <= antic_q ? S_HDR : S_SEGC;
				end
				S_HDR: if (rd_ack) begin
					hidx_q <= hidx_q + 2'd1;
					unique case (hidx_q)
						2'd0: fsize_q   <= cur;
						2'd1: station_q <= cur;
						2'd2: sap_q     <= cur[7:0];
						2'd3: hdr_q     <= cur;
					endcase
					if (hidx_q == 2'd3)
						state_q <= S_SEGC;
					if (ftype == tdc_pkg::FT_INVALID) begin
						has_err_q <= 1'b1;
						err_q     <= tdc_pkg::CODE_BADTYPE;
					end
				end
				S_SEGC: if (rd_ack) begin
					cnt_q   <= cur;
					more_q  <= cur[0] && seg_q != 2'd2;
					state_q <= S_SEGH;
				end
				S_SEGH: if (rd_ack) begin
					daddr_q[31:16] <= cur;
					state_q        <= S_SEGL;
				end
				S_SEGL: if (rd_ack) begin
					daddr_q[15:0] <= cur;
					state_q       <= (cnt_q == 16'h0000 || has_err_q) ? S_SEGE : S_DRD;
				end
				S_DRD: if (rd_ack) begin
					byte_q  <= out_byte;
					last_q  <= end_q && sum_q + 16'h0001 == fsize_q;
					txv_q   <= 1'b1;
					state_q <= S_DOUT;
				end
				S_DOUT: if (tx_ready) begin
					txv_q   <= 1'b0;
					daddr_q <= daddr_q + 32'h0000_0001;
					cnt_q   <= cnt_q - 16'h0001;
					sum_q   <= sum_q + 16'h0001;
					pos_q   <= pos_q + 16'h0001;
					state_q <= cnt_q == 16'h0001 ? S_SEGE : S_DRD;
				end
				S_SEGE: begin
					seg_q   <= seg_q + 2'd1;
					state_q <= more_q ? S_SEGC : S_LEND;
				end
				S_LEND: begin
					if (end_q) begin
						if (!has_err_q && sum_q != fsize_q) begin
							has_err_q <= 1'b1;
							err_q     <= tdc_pkg::CODE_BADLEN;
						end
						state_q <= (has_err_q || sum_q != fsize_q) ? S_WB : S_TXW;
					end else if (fwd_q[0]) begin
						lerr_q  <= 1'b1;
						state_q <= S_IDLE;
					end else begin
						list_q  <= fwd_q;
						antic_q <= 1'b0;
						state_q <= S_CSTAT;
					end
				end
				S_TXW: if (tx_done) begin
					fs_q <= tx_fs;
					if (tx_fail) begin
						has_err_q <= 1'b1;
						err_q     <= tdc_pkg::CODE_TXFAIL;
					end
					state_q <= S_WB;
				end
				S_WB: if (mem_ack) begin
					word_q  <= wb_word;
					irq_q   <= req_q[tdc_pkg::B_FINT];
					antic_q <= 1'b1;
					if (fwd_q[0]) begin
						state_q <= S_REFWD;
					end else begin
						list_q  <= fwd_q;
						state_q <= S_CSTAT;
					end
				end
				S_REFWD: if (rd_ack) begin
					fwd_q[15:0] <= cur;
					if (cur[0]) begin
						done_q  <= 1'b1;
						state_q <= S_IDLE;
					end else begin
						list_q  <= {fwd_q[31:16], cur};
						state_q <= S_CSTAT;
					end
				end
			endcase
		end
	end

	// ****************************************************
	// Checks
	// ****************************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	property p_wb_word;
		mem_we |-> !mem_wdata[0] && mem_wdata[1] && mem_wdata[4:2] == req_q[4:2];
	endproperty
	a_wb_word: assert property (p_wb_word) else $error("done word bits wrong");

	property p_wb_addr;
		mem_req && mem_we |-> mem_addr == sof_q + tdc_pkg::OFS_CSTAT;
	endproperty
	a_wb_addr: assert property (p_wb_addr) else $error("write outside start status");

	property p_suspend;
		state_q == S_CSTAT && rd_ack && antic_q && !cur[0] |=> state_q == S_SUSP && !mem_req;
	endproperty
	a_suspend: assert property (p_suspend) else $error("no suspend on clear go");

	property p_tx_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("stream byte dropped");

	property p_irq;
		frame_irq |-> $past(state_q) == S_WB && $past(mem_ack) && $past(req_q[4]);
	endproperty
	a_irq: assert property (p_irq) else $error("stray frame interrupt");

	property p_done;
		cmd_done |-> $past(state_q) == S_REFWD && $past(cur[0]) && state_q == S_IDLE;
	endproperty
	a_done: assert property (p_done) else $error("command ended without odd link");

	property p_badtype;
		state_q == S_HDR && rd_ack && ftype == tdc_pkg::FT_INVALID
			|=> has_err_q && err_q == tdc_pkg::CODE_BADTYPE;
	endproperty
	a_badtype: assert property (p_badtype) else $error("invalid type not flagged");

	property p_route;
		state_q == S_DRD && rd_ack && rt_set |=> tx_valid && tx_data[7];
	endproperty
	a_route: assert property (p_route) else $error("routing bit missing");

	property p_relink;
		state_q == S_REFWD && rd_ack && !cur[0] |=> state_q == S_CSTAT ##1 mem_req;
	endproperty
	a_relink: assert property (p_relink) else $error("even link not followed");
endmodule

// *** verilog/tdc_pkg.sv ***
// Shared constants of the transmit descriptor-chain engine
package tdc_pkg;
	// ****************************************************
	// Register map (byte addresses on the AXI4-Lite port)
	// ****************************************************
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_LIST      = 8'h04;
	localparam logic [7:0]  REG_NODE_HI   = 8'h08;
	localparam logic [7:0]  REG_NODE_LO   = 8'h0C;
	localparam logic [7:0]  REG_STATUS    = 8'h10;
	localparam logic [7:0]  REG_LAST_LIST = 8'h14;
	localparam logic [7:0]  REG_LAST_WORD = 8'h18;
	localparam int          CTRL_START    = 0;
	localparam int          CTRL_KICK     = 1;
	localparam int          CTRL_LINK_EN  = 2;
	localparam logic [31:0] RST_WORD      = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;
	// ****************************************************
	// Transmit list layout (byte offsets in host memory)
	// ****************************************************
	localparam logic [31:0] OFS_FWD_HI    = 32'h0000_0000;
	localparam logic [31:0] OFS_FWD_LO    = 32'h0000_0002;
	localparam logic [31:0] OFS_CSTAT     = 32'h0000_0004;
	localparam logic [31:0] OFS_FSIZE     = 32'h0000_0006;
	localparam logic [31:0] OFS_SEG0      = 32'h0000_0008;
	localparam logic [31:0] SEG_STRIDE    = 32'h0000_0006;
	localparam logic [31:0] OFS_STATION   = 32'h0000_001A;
	localparam logic [31:0] OFS_SAP       = 32'h0000_001C;
	localparam logic [31:0] OFS_HDRLEN    = 32'h0000_001E;
	// ****************************************************
	// Control/status word bits, codes and frame types
	// ****************************************************
	localparam int          B_GO          = 0;
	localparam int          B_DONE        = 1;
	localparam int          B_START       = 2;
	localparam int          B_END         = 3;
	localparam int          B_FINT        = 4;
	localparam int          B_ERR         = 5;
	localparam int          B_PASS_CRC    = 6;
	localparam int          B_PASS_SRC    = 7;
	localparam logic [7:0]  CODE_TXFAIL   = 8'h23;
	localparam logic [7:0]  CODE_BADLEN   = 8'h28;
	localparam logic [7:0]  CODE_BADTYPE  = 8'hF0;
	localparam logic [7:0]  FS_ZERO       = 8'h00;
	localparam logic [7:0]  FS_COPIED     = 8'hCC;
	localparam logic [2:0]  FT_DIRECT     = 3'h0;
	localparam logic [2:0]  FT_IFRAME     = 3'h6;
	localparam logic [2:0]  FT_INVALID    = 3'h7;
	localparam logic [15:0] RT_HDR_MAX    = 16'h000E;
	localparam logic [15:0] SA_FIRST_POS  = 16'h0008;
	localparam logic [15:0] SA_LAST_POS   = 16'h000D;
endpackage

// *** verilog/tdc_reg_if.sv ***
// Register fields passed between the bus slave and the list engine
`timescale 1ns/1ns
interface tdc_reg_if;
	logic        start_p;
	logic        kick_p;
	logic        link_en;
	logic [31:0] list_addr;
	logic [47:0] node_addr;
	logic        busy;
	logic        suspended;
	logic        list_err;
	logic [31:0] last_list;
	logic [15:0] last_word;
	modport slv  (output start_p, kick_p, link_en, list_addr, node_addr,
	              input busy, suspended, list_err, last_list, last_word);
	modport core (input start_p, kick_p, link_en, list_addr, node_addr,
	              output busy, suspended, list_err, last_list, last_word);
endinterface
